// [rtl/fcl_defs.svh]
`ifndef FCL_DEFS_SVH
`define FCL_DEFS_SVH
// ****************************************
// Instruction and data register sizes
// ****************************************
`define FCL_IR_W 8
`define FCL_DR_W 32
`define FCL_IR_CAPTURE 8'h01
// ****************************************
// Instruction opcodes
// ****************************************
`define FCL_OP_SCAN 8'h01
`define FCL_OP_OFFLINE 8'h02
`define FCL_OP_BACKGND 8'h03
`define FCL_OP_EXIT 8'h04
`define FCL_OP_REFRESH 8'h05
`define FCL_OP_WR_SRAM 8'h06
`define FCL_OP_WR_NVM 8'h07
`define FCL_OP_RD_SRAM 8'h08
`define FCL_OP_RD_NVM 8'h09
`define FCL_OP_SECURE 8'h0A
`define FCL_OP_ERASE 8'h0B
`define FCL_OP_PINMODE 8'h0C
`define FCL_OP_BYPASS 8'hFF
// ****************************************
// Pin hold modes and reset values
// ****************************************
`define FCL_PM_HIGH 2'h0
`define FCL_PM_LOW 2'h1
`define FCL_PM_TRI 2'h2
`define FCL_PM_HOLD 2'h3
`define FCL_PM_RESET 2'h2
`endif

// [rtl/fcl_pkg.sv]
package fcl_pkg;
  // ****************************************
  // Test port controller and loader states
  // ****************************************
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAUSE_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
    TAP_PAUSE_IR, TAP_EX2_IR, TAP_UPD_IR
  } fcl_tap_t;
  typedef enum logic [1:0] {LD_LOAD, LD_USER, LD_ERASE} fcl_ld_t;
endpackage : fcl_pkg

// [rtl/fcl_config_loader.sv]
`timescale 1ns/10ps
`include "fcl_defs.svh"
// Overview of operation
// (R1) Off-line mode: scan cells drive all pins; scanOe comes from the hold mode, so tristate mode drives none
// (R2) Background mode keeps user design running
// (R3) Power-up loads SRAM from non-volatile memory
// (R4) Refresh command reloads SRAM from non-volatile
// (R5) SRAM writable over test port from power-up
// (R6) Pins held high, low, tristate or frozen
// (R7) Security set blocks readback of both memories
// (R8) Only erase clears the security bit; srst clears it too
// (R9) Enter user mode with registers preset
// (R10) Programmer loads instruction before shifting data

// ****************************************
// Write data buffer
// ****************************************
module fcl_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;

  // Extra pointer bit tells full from empty
  assign inReady = (wrPtr ^ rdPtr) != {1'b1, {AW{1'b0}}};
  assign outValid = wrPtr != rdPtr;
  assign outData = mem[rdPtr[AW-1:0]];

  always_comb begin
    next_wrPtr = (inValid && inReady) ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = (outValid && outReady) ? rdPtr + 1'b1 : rdPtr;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (inValid && inReady) begin
      mem[wrPtr[AW-1:0]] <= inData;
    end
  end
endmodule : fcl_fifo

// ****************************************
// Configuration loader
// ****************************************
module fcl_config_loader
  import fcl_pkg::*;
#(
  parameter int NPINS = 8,
  parameter int CFG_DEPTH = 64,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn,
  input wire logic [NPINS-1:0] userPinOut,
  input wire logic [NPINS-1:0] userPinOe,
  output logic [NPINS-1:0] pinOut,
  output logic [NPINS-1:0] pinOe,
  output logic userMode,
  output logic presetPulse,
  output logic offline,
  output logic background,
  output logic secure
);
  localparam int AW = $clog2(CFG_DEPTH);
  localparam int DW = `FCL_DR_W;

  logic tckS1, tckS2, tckS3, tmsS1, tmsS, tdiS1, tdiS;
  logic tckRise, tckFall;
  fcl_tap_t tap, next_tap;
  fcl_ld_t ld, next_ld;
  logic [`FCL_IR_W-1:0] ir, irSh, next_ir, next_irSh;
  logic [DW-1:0] drSh, next_drSh, rdWord, fOutWord;
  logic [AW-1:0] ldAddr, next_ldAddr, rdAddr, next_rdAddr, wrAddr, next_wrAddr;
  logic [NPINS-1:0] scanCells, next_scanCells, scanOe, next_scanOe;
  logic [NPINS-1:0] next_pinOut, next_pinOe;
  logic [1:0] pinMode, next_pinMode;
  logic [DW:0] pendWord, next_pendWord, fOutData;
  logic pendValid, next_pendValid, fInReady, fOutValid, fOutReady;
  logic next_offline, next_background, next_secure, next_userMode, next_presetPulse;
  logic next_tdo, next_tdoEn;
  logic capDr, shDr, updDr, capIr, shIr, updIr, readOp, ldLast, progOk;
  logic sramWe, nvmWe;
  logic [AW-1:0] sramWa, nvmWa;
  logic [DW-1:0] sramWd, nvmWd;
  logic [DW-1:0] sram [CFG_DEPTH];
  logic [DW-1:0] nvm [CFG_DEPTH];

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  always_ff @(posedge core_clk) begin
    tckS1 <= tck;
    tckS2 <= tckS1;
    tckS3 <= tckS2;
    tmsS1 <= tms;
    tmsS <= tmsS1;
    tdiS1 <= tdi;
    tdiS <= tdiS1;
  end

  assign tckRise = tckS2 && !tckS3;
  assign tckFall = !tckS2 && tckS3;

  // ****************************************
  // Test port controller
  // ****************************************
  always_comb begin
    next_tap = tap;
    if (tckRise) begin
      case (tap)
        TAP_RESET: next_tap = tmsS ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: next_tap = tmsS ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: next_tap = tmsS ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR: next_tap = tmsS ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR: next_tap = tmsS ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: next_tap = tmsS ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: next_tap = tmsS ? TAP_EX2_DR : TAP_PAUSE_DR;
        TAP_EX2_DR: next_tap = tmsS ? TAP_UPD_DR : TAP_SH_DR;
        TAP_UPD_DR: next_tap = tmsS ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR: next_tap = tmsS ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR: next_tap = tmsS ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR: next_tap = tmsS ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: next_tap = tmsS ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: next_tap = tmsS ? TAP_EX2_IR : TAP_PAUSE_IR;
        TAP_EX2_IR: next_tap = tmsS ? TAP_UPD_IR : TAP_SH_IR;
        TAP_UPD_IR: next_tap = tmsS ? TAP_SEL_DR : TAP_IDLE;
        default: next_tap = TAP_RESET;
      endcase
    end
  end

  assign capDr = tckRise && tap == TAP_CAP_DR;
  assign shDr = tckRise && tap == TAP_SH_DR;
  assign updDr = tckRise && tap == TAP_UPD_DR;
  assign capIr = tckRise && tap == TAP_CAP_IR;
  assign shIr = tckRise && tap == TAP_SH_IR;
  assign updIr = tckRise && tap == TAP_UPD_IR;
  assign readOp = ir == `FCL_OP_RD_SRAM || ir == `FCL_OP_RD_NVM;
  assign rdWord = (ir == `FCL_OP_RD_NVM) ? nvm[rdAddr] : sram[rdAddr];
  assign ldLast = ldAddr == AW'(CFG_DEPTH - 1);
  assign progOk = offline || background;
  assign fOutWord = fOutData[DW-1:0];
  assign fOutReady = ld == LD_USER;

  // Words wait here while the loader is outside LD_USER
  fcl_fifo #(.WIDTH(DW + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .inValid(pendValid),
    .inReady(fInReady),
    .inData(pendWord),
    .outValid(fOutValid),
    .outReady(fOutReady),
    .outData(fOutData)
  );

  // ****************************************
  // Shift registers and commands
  // ****************************************
  always_comb begin
    next_irSh = capIr ? `FCL_IR_CAPTURE : (shIr ? {tdiS, irSh[`FCL_IR_W-1:1]} : irSh);
    next_ir = (tap == TAP_RESET) ? `FCL_OP_BYPASS : (updIr ? irSh : ir);
    next_drSh = drSh;
    next_rdAddr = updIr ? '0 : rdAddr;
    if (capDr) begin
      next_drSh = (readOp && !secure) ? rdWord : '0; // see (R7)
      if (readOp) begin
        next_rdAddr = rdAddr + 1'b1;
      end
    end else if (shDr) begin
      next_drSh = {tdiS, drSh[DW-1:1]};
    end
    next_tdo = tdo;
    next_tdoEn = tdoEn;
    if (tckFall) begin
      next_tdo = (tap == TAP_SH_IR) ? irSh[0] : drSh[0];
      next_tdoEn = tap == TAP_SH_IR || tap == TAP_SH_DR;
    end
    next_ld = ld;
    next_ldAddr = ldAddr;
    next_wrAddr = wrAddr;
    next_offline = offline;
    next_background = background;
    next_secure = secure;
    next_pinMode = pinMode;
    next_scanCells = scanCells;
    next_scanOe = scanOe;
    next_pendWord = pendWord;
    next_pendValid = pendValid && !fInReady;
    sramWe = 1'b0;
    sramWa = ldAddr;
    sramWd = nvm[ldAddr];
    nvmWe = 1'b0;
    nvmWa = ldAddr;
    nvmWd = '1;
    case (ld)
      LD_LOAD: begin
        sramWe = 1'b1; // see (R3)
        next_ldAddr = ldAddr + 1'b1;
        if (ldLast) begin
          next_ld = LD_USER;
        end
      end
      LD_ERASE: begin
        nvmWe = 1'b1;
        next_ldAddr = ldAddr + 1'b1;
        if (ldLast) begin
          next_ld = LD_USER;
          next_secure = 1'b0; // see (R8)
        end
      end
      LD_USER: begin
        // Loader owns the memories outside LD_USER, so draining waits
        if (fOutValid) begin
          next_wrAddr = wrAddr + 1'b1;
          sramWe = !fOutData[DW]; // see (R5)
          nvmWe = fOutData[DW];
          sramWa = wrAddr;
          nvmWa = wrAddr;
          sramWd = fOutWord;
          nvmWd = fOutWord;
        end
      end
      default: next_ld = LD_LOAD;
    endcase
    if (updIr) begin
      case (irSh)
        `FCL_OP_OFFLINE: begin
          next_offline = 1'b1; // see (R1)
          next_background = 1'b0;
          // Scan cells start from the selected hold state
          case (pinMode)
            `FCL_PM_HIGH: {next_scanCells, next_scanOe} = {{NPINS{1'b1}}, {NPINS{1'b1}}};
            `FCL_PM_LOW: {next_scanCells, next_scanOe} = {{NPINS{1'b0}}, {NPINS{1'b1}}};
            `FCL_PM_TRI: {next_scanCells, next_scanOe} = {pinOut, {NPINS{1'b0}}};
            default: {next_scanCells, next_scanOe} = {pinOut, pinOe}; // see (R6)
          endcase
        end
        `FCL_OP_BACKGND: next_background = !offline; // see (R2)
        `FCL_OP_EXIT, `FCL_OP_REFRESH: begin
          next_offline = 1'b0;
          next_background = 1'b0;
          next_ld = LD_LOAD; // see (R4)
          next_ldAddr = '0;
        end
        `FCL_OP_SECURE: next_secure = 1'b1;
        `FCL_OP_ERASE: begin
          if (progOk && ld == LD_USER) begin
            next_ld = LD_ERASE;
            next_ldAddr = '0;
          end
        end
        `FCL_OP_WR_SRAM, `FCL_OP_WR_NVM: next_wrAddr = '0;
        default: ;
      endcase
    end
    if (updDr) begin
      case (ir)
        `FCL_OP_SCAN: next_scanCells = drSh[NPINS-1:0];
        `FCL_OP_PINMODE: next_pinMode = drSh[1:0];
        `FCL_OP_WR_SRAM: {next_pendValid, next_pendWord} = {1'b1, 1'b0, drSh}; // see (R5)
        `FCL_OP_WR_NVM: begin
          if (progOk) begin
            {next_pendValid, next_pendWord} = {1'b1, 1'b1, drSh};
          end
        end
        default: ;
      endcase
    end
    // Off-line wins over hold, hold over user pins
    if (offline) begin
      next_pinOut = scanCells; // see (R1)
      next_pinOe = scanOe;
    end else if (ld == LD_LOAD) begin
      case (pinMode) // see (R6)
        `FCL_PM_HIGH: {next_pinOut, next_pinOe} = {{NPINS{1'b1}}, {NPINS{1'b1}}};
        `FCL_PM_LOW: {next_pinOut, next_pinOe} = {{NPINS{1'b0}}, {NPINS{1'b1}}};
        `FCL_PM_TRI: {next_pinOut, next_pinOe} = {pinOut, {NPINS{1'b0}}};
        default: {next_pinOut, next_pinOe} = {pinOut, pinOe};
      endcase
    end else begin
      next_pinOut = userPinOut; // see (R2)
      next_pinOe = userPinOe;
    end
    next_userMode = !next_offline && next_ld != LD_LOAD; // see (R2)
    next_presetPulse = ld == LD_LOAD && next_ld == LD_USER && !next_offline; // see (R9)
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tap <= TAP_RESET;
      ld <= LD_LOAD;
      ir <= `FCL_OP_BYPASS;
      irSh <= '0;
      drSh <= '0;
      ldAddr <= '0;
      rdAddr <= '0;
      wrAddr <= '0;
      scanCells <= '0;
      scanOe <= '0;
      pinMode <= `FCL_PM_RESET;
      pendWord <= '0;
      pendValid <= 1'b0;
      offline <= 1'b0;
      background <= 1'b0;
      secure <= 1'b0;
      pinOut <= '0;
      pinOe <= '0;
      userMode <= 1'b0;
      presetPulse <= 1'b0;
      tdo <= 1'b0;
      tdoEn <= 1'b0;
    end else begin
      tap <= next_tap;
      ld <= next_ld;
      ir <= next_ir;
      irSh <= next_irSh;
      drSh <= next_drSh;
      ldAddr <= next_ldAddr;
      rdAddr <= next_rdAddr;
      wrAddr <= next_wrAddr;
      scanCells <= next_scanCells;
      scanOe <= next_scanOe;
      pinMode <= next_pinMode;
      pendWord <= next_pendWord;
      pendValid <= next_pendValid;
      offline <= next_offline;
      background <= next_background;
      secure <= next_secure;
      pinOut <= next_pinOut;
      pinOe <= next_pinOe;
      userMode <= next_userMode;
      presetPulse <= next_presetPulse;
      tdo <= next_tdo;
      tdoEn <= next_tdoEn;
    end
  end

  // Memory contents survive reset on purpose
  always_ff @(posedge core_clk) begin
    if (sramWe) begin
      sram[sramWa] <= sramWd;
    end
    if (nvmWe) begin
      nvm[nvmWa] <= nvmWd;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  offline_pins_a: assert property (@(posedge core_clk) disable iff (srst) // see (R1)
    offline |=> pinOut == $past(scanCells)) else $error("pins not from scan cells");
  background_run_a: assert property (@(posedge core_clk) disable iff (srst) // see (R2)
    background && ld != LD_LOAD |-> userMode) else $error("user mode lost in background");
  powerup_load_a: assert property (@(posedge core_clk) disable iff (srst) // see (R3)
    $past(srst) |-> ld == LD_LOAD && ldAddr == '0) else $error("no load after reset");
  refresh_load_a: assert property (@(posedge core_clk) disable iff (srst) // see (R4)
    updIr && irSh == `FCL_OP_REFRESH |=> ld == LD_LOAD && ldAddr == '0)
    else $error("refresh did not reload");
  sram_write_a: assert property (@(posedge core_clk) disable iff (srst) // see (R5)
    fOutValid && fOutReady && !fOutData[DW] |=> sram[$past(wrAddr)] == $past(fOutWord))
    else $error("buffered word not written");
  pins_held_a: assert property (@(posedge core_clk) disable iff (srst) // see (R6)
    (ld == LD_LOAD && !offline && pinMode == `FCL_PM_LOW) [*2] |-> pinOut == '0 && pinOe == '1)
    else $error("pins not held low during load");
  secure_read_a: assert property (@(posedge core_clk) disable iff (srst) // see (R7)
    capDr && readOp && secure |=> drSh == '0) else $error("readback while secure");
  secure_hold_a: assert property (@(posedge core_clk) disable iff (srst) // see (R8)
    secure && !(ld == LD_ERASE && ldLast) |=> secure) else $error("security cleared early");
  preset_entry_a: assert property (@(posedge core_clk) disable iff (srst) // see (R9)
    presetPulse |-> userMode && $past(ld) == LD_LOAD) else $error("preset outside entry");
endmodule : fcl_config_loader

// [tb/fcl_jtag_host.sv]
`timescale 1ns/10ps
// ****************************************
// Test port programmer model
// ****************************************
module fcl_jtag_host #(
  parameter real HALF = 62.5
) (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdoEn
);
  logic enSeen, shiftEn;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    enSeen = 1'b0;
    shiftEn = 1'b0;
  end

  // Tck parks low between frames, never free-running
  task automatic pulse(input logic m, input logic d, output logic q);
    // Non-blocking so a pin edge on a core edge cannot race the sampler
    tms <= m;
    tdi <= d;
    #(HALF);
    q = tdo;
    enSeen = tdoEn;
    tck <= 1'b1;
    #(HALF);
    tck <= 1'b0;
  endtask : pulse

  // Tdi toggles outside shifts so a stale bit is never seen
  task automatic moves(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      pulse(seq[i], ~tdi, q);
    end
  endtask : moves

  task automatic tapReset();
    moves(8'h1F, 6);
  endtask : tapReset

  // Idle to shift, bit 0 first, back to idle via update
  task automatic scan(input logic isIr, input logic [31:0] din, output logic [31:0] dout);
    int n;
    logic q;
    n = isIr ? 8 : 32;
    dout = '0;
    moves(isIr ? 8'h03 : 8'h01, isIr ? 4 : 3);
    shiftEn = 1'b1;
    for (int i = 0; i < n; i++) begin
      pulse(i == n - 1, din[i], q);
      dout[i] = q;
      shiftEn = shiftEn & enSeen;
    end
    moves(8'h01, 2);
  endtask : scan
endmodule : fcl_jtag_host

// [tb/tb_fcl_config_loader.sv]
`timescale 1ns/10ps
`include "fcl_defs.svh"
module tb_fcl_config_loader;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic coreClk, srst, tck, tms, tdi, tdo, tdoEn, userMode, presetPulse;
  logic offline, background, secure, saw;
  logic [7:0] userPinOut, userPinOe, pinOut, pinOe, heldPins;
  logic [31:0] lastRead, v;
  logic [31:0] words [4];
  logic [31:0] expQ [$];
  int nErrors = 0;
  int totalChecks = 0;
  int cycles = 0;
  integer seed = 14373;
  event readDone;

  fcl_config_loader DUT (.core_clk(coreClk), .srst(srst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEn(tdoEn), .userPinOut(userPinOut), .userPinOe(userPinOe),
    .pinOut(pinOut), .pinOe(pinOe), .userMode(userMode), .presetPulse(presetPulse),
    .offline(offline), .background(background), .secure(secure));
  fcl_jtag_host host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEn(tdoEn));

  initial begin
    coreClk = 1'b0;
    forever #2 coreClk = ~coreClk;
  end

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nErrors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finalReport();
    $display("checks %0d errors %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finalReport

  initial begin
    forever begin
      @(readDone);
      if (expQ.size() == 0) begin
        nErrors++;
        $display("CHECK FAILED read word expected none seen %h", lastRead);
      end else begin
        check("read word", lastRead, expQ.pop_front());
      end
    end
  end

  // Ceiling well above the expected run of about 32500 cycles
  initial begin
    forever begin
      @(posedge coreClk);
      cycles++;
      if (cycles == 60000) begin
        nErrors++;
        $display("CHECK FAILED timeout expected done seen hang");
        finalReport();
      end
    end
  end

  // ****************************************
  // Stimulus tasks
  // ****************************************
  // Scans start and end on a falling core edge so outputs are read settled
  task automatic op(input logic [7:0] code);
    logic [31:0] d;
    @(negedge coreClk);
    host.scan(1'b1, {24'h0, code}, d);
    @(negedge coreClk);
    check("tdoEn idle", 32'(tdoEn), 32'h0);
  endtask : op

  task automatic wr(input logic [31:0] w);
    logic [31:0] d;
    @(negedge coreClk);
    host.scan(1'b0, w, d);
    @(negedge coreClk);
    check("tdoEn shift", 32'(host.shiftEn), 32'h1);
  endtask : wr

  task automatic rd(input logic [31:0] exp);
    expQ.push_back(exp);
    @(negedge coreClk);
    host.scan(1'b0, 32'h0, lastRead);
    ->readDone;
    @(negedge coreClk);
    check("tdoEn read", 32'(host.shiftEn), 32'h1);
  endtask : rd

  task automatic waitCore(input int n);
    repeat (n) @(negedge coreClk);
  endtask : waitCore

  task automatic waitUser(output logic sawPulse);
    sawPulse = 1'b0;
    for (int i = 0; i < 300 && userMode !== 1'b1; i++) begin
      @(negedge coreClk);
      if (presetPulse === 1'b1) sawPulse = 1'b1;
    end
  endtask : waitUser

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    srst = 1'b1;
    userPinOut = 8'h00;
    userPinOe = 8'h00;
    waitCore(6);
    srst = 1'b0;
    waitCore(2);
    check("pinOe load", 32'(pinOe), 32'h0);
    check("userMode load", 32'(userMode), 32'h0);
    waitUser(saw);
    check("presetPulse", 32'(saw), 32'h1);
    check("userMode up", 32'(userMode), 32'h1);
    host.tapReset();
    op(`FCL_OP_BACKGND);
    waitCore(4);
    userPinOut = 8'($random(seed));
    userPinOe = 8'($random(seed));
    waitCore(4);
    check("background", 32'(background), 32'h1);
    check("userMode bg", 32'(userMode), 32'h1);
    check("pinOut bg", 32'(pinOut), 32'(userPinOut));
    check("pinOe bg", 32'(pinOe), 32'(userPinOe));
    op(`FCL_OP_ERASE);
    op(`FCL_OP_WR_NVM);
    for (int i = 0; i < 4; i++) begin
      words[i] = $random(seed);
      wr(words[i]);
    end
    op(`FCL_OP_EXIT);
    check("userMode reload", 32'(userMode), 32'h0);
    check("pinOe reload", 32'(pinOe), 32'h0);
    waitUser(saw);
    check("background off", 32'(background), 32'h0);
    op(`FCL_OP_RD_NVM);
    for (int i = 0; i < 4; i++) rd(words[i]);
    rd(32'hFFFFFFFF);
    op(`FCL_OP_WR_SRAM);
    wr(~words[0]);
    wr(~words[1]);
    op(`FCL_OP_RD_SRAM);
    rd(~words[0]);
    rd(~words[1]);
    // Freeze mode: user pins move during the reload, pins must not follow
    op(`FCL_OP_PINMODE);
    wr(32'h3);
    heldPins = userPinOut;
    op(`FCL_OP_REFRESH);
    userPinOut = ~heldPins;
    waitCore(3);
    check("pinOut frozen", 32'(pinOut), 32'(heldPins));
    check("pinOe frozen", 32'(pinOe), 32'(userPinOe));
    waitUser(saw);
    check("presetPulse refresh", 32'(saw), 32'h1);
    op(`FCL_OP_RD_SRAM);
    rd(words[0]);
    rd(words[1]);
    check("pinOut user", 32'(pinOut), 32'(userPinOut));
    op(`FCL_OP_PINMODE);
    wr(32'h1);
    op(`FCL_OP_OFFLINE);
    waitCore(4);
    check("offline", 32'(offline), 32'h1);
    check("userMode off", 32'(userMode), 32'h0);
    check("pinOut low", 32'(pinOut), 32'h0);
    check("pinOe low", 32'(pinOe), 32'hFF);
    op(`FCL_OP_SCAN);
    v = $random(seed);
    wr(v);
    waitCore(4);
    check("pinOut scan", 32'(pinOut), 32'(v[7:0]));
    op(`FCL_OP_EXIT);
    check("pinOut hold", 32'(pinOut), 32'h0);
    check("pinOe hold", 32'(pinOe), 32'hFF);
    waitUser(saw);
    check("offline off", 32'(offline), 32'h0);
    op(`FCL_OP_SECURE);
    check("secure set", 32'(secure), 32'h1);
    op(`FCL_OP_RD_NVM);
    rd(32'h0);
    op(`FCL_OP_RD_SRAM);
    rd(32'h0);
    op(`FCL_OP_REFRESH);
    waitUser(saw);
    check("secure kept", 32'(secure), 32'h1);
    op(`FCL_OP_BACKGND);
    op(`FCL_OP_ERASE);
    waitCore(100);
    check("secure erased", 32'(secure), 32'h0);
    waitCore(4);
    finalReport();
  end
endmodule : tb_fcl_config_loader
